// ==== hw/tta_alert_top.sv ====
// overheat assertion timer, limit flag, alert masking and pin roles
// assumes a byte register port from the serial bus engine, one core clock,
// fault sources and fan state on the same clock
//
// Behaviour
// - mask two bits gate per-source alerts
// - bit five masks speed four or timer
// - config three bit zero enables alert pin
// - config four selects shared pin role
// - timer needs enable bit and role
// - full-speed bit forces fans while asserted, in overheat pin role only
// - only fans already running get forced
// - count while asserted, hold otherwise
// - timer saturates until read
// - first assertion sets bit zero
// - timer read clears the count
// - read while asserted restarts at one
// - limit zero re-flags after read
// - timer above limit sets flag, alerts
// - mask blocks alert, not flag
// - limit zero first assertion, one 45ms
// - eight-bit limit up to 5.8 s
// - timer read clears limit flag
// - status bits sticky until read absent
// - bit five speed four or timer
// - alert low until status read
`timescale 1ns/1ps
module tta_alert_top #(
	parameter int TICK_CYCLES = tta_pkg::TTA_TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic overheat_pin_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic diode_two_fault,
	input wire logic diode_one_fault,
	input wire logic [3:0] speed_fault,
	input wire logic overtemp_event,
	input wire logic [2:0] fan_manual_mode,
	input wire logic [23:0] fan_duty,
	input wire logic [2:0] fan_above_tmin,
	output logic [2:0] fan_full_speed,
	output logic smbalert_n,
	output logic alert_pin5_out,
	output logic alert_pin5_oe_n,
	output logic shared_pin_out,
	output logic shared_pin_oe_n,
	output logic timer_active
);
	import tta_pkg::*;

	// registers
	logic [7:0] mask_two_q;
	logic [7:0] config_three_q;
	logic [7:0] limit_q;
	logic [7:0] config_four_q;
	logic [7:0] status_two_q;
	logic [7:0] status_two_d;
	logic [7:0] rdata_q;
	logic [2:0] full_speed_q;
	logic alert_n_q;
	logic pin5_oe_n_q;
	logic shared_oe_n_q;
	logic timer_active_q;

	tta_tmr_if tif ();

	// overheat pin conditioning
	logic pin_asserted;

	tta_sync_filt u_filt (
		.mclk(mclk),
		.rstn(rstn),
		.pin_n(overheat_pin_n),
		.asserted(pin_asserted)
	);

	tta_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.mclk(mclk),
		.rstn(rstn),
		.tif(tif)
	);

	// address decode
	wire hit_status_one = (reg_addr == TTA_OFF_STATUS_ONE);
	wire hit_status_two = (reg_addr == TTA_OFF_STATUS_TWO);
	wire hit_mask_two = (reg_addr == TTA_OFF_MASK_TWO);
	wire hit_config_three = (reg_addr == TTA_OFF_CONFIG_THREE);
	wire hit_timer = (reg_addr == TTA_OFF_TIMER);
	wire hit_limit = (reg_addr == TTA_OFF_LIMIT);
	wire hit_config_four = (reg_addr == TTA_OFF_CONFIG_FOUR);
	wire rd_status_two = reg_rd && hit_status_two;
	wire rd_timer = reg_rd && hit_timer;

	wire [1:0] role = config_four_q[1:0];
	wire role_overheat = (role == TTA_ROLE_OVERHEAT);
	wire role_alert = (role == TTA_ROLE_ALERT);
	wire role_speed = (role == TTA_ROLE_SPEED_IN);

	wire timer_func = role_overheat && config_three_q[TTA_C3_TIMER_EN];
	wire pin_low = role_overheat && pin_asserted;

	// timer runs only when the function is on
	assign tif.active = timer_func && pin_asserted;
	assign tif.rd_clr = rd_timer;

	// limit zero trips at first assertion
	// limit ff never trips, since the timer saturates at ff
	// stale value in the read cycle is masked so the clear sticks
	wire timer_over = timer_func && !rd_timer && (tif.value > limit_q);

	wire speed_four_cond = role_speed && speed_fault[3];
	wire bit5_cond = timer_func ? timer_over : speed_four_cond;

	// live conditions per status bit
	wire [7:0] cond = {
		diode_two_fault,
		diode_one_fault,
		bit5_cond,
		speed_fault[2],
		speed_fault[1],
		speed_fault[0],
		overtemp_event,
		1'b0
	};

	wire [7:0] clr_by_status = rd_status_two ? ~cond : 8'h00;
	wire [7:0] clr_by_timer = (rd_timer && timer_func) ? 8'h20 : 8'h00;
	wire [7:0] clr_mask = clr_by_status | clr_by_timer;

	// limit zero sets again via cond
	always_comb begin
		status_two_d = (status_two_q & ~clr_mask) | cond;
		status_two_d[0] = 1'b0;
	end

	wire [7:0] unmasked = status_two_d & ~mask_two_q;
	wire alert_any = |unmasked;

	wire pin5_drive = config_three_q[TTA_C3_ALERT_EN] && alert_any;
	wire shared_drive = role_alert && alert_any;

	logic [2:0] fan_running;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_fan
			wire duty_nonzero = (fan_duty[gi*8 +: 8] != 8'h00);
			assign fan_running[gi] = fan_manual_mode[gi] ? duty_nonzero : fan_above_tmin[gi];
		end
	endgenerate

	wire [2:0] full_speed_d = (config_three_q[TTA_C3_FULL_SPEED] && pin_low) ?
		fan_running : 3'b000;

	// status one shows only the summary bit here
	wire [7:0] status_one_view = {|status_two_q, 7'h00};

	wire [7:0] rdata_d =
		hit_status_one ? status_one_view :
		hit_status_two ? status_two_q :
		hit_mask_two ? mask_two_q :
		hit_config_three ? config_three_q :
		hit_timer ? tif.value :
		hit_limit ? limit_q :
		hit_config_four ? config_four_q :
		8'h00;

	// software writable registers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			mask_two_q <= TTA_RST_MASK_TWO;
			config_three_q <= TTA_RST_CONFIG_THREE;
			limit_q <= TTA_RST_LIMIT;
			config_four_q <= TTA_RST_CONFIG_FOUR;
		end else if (reg_wr) begin
			if (hit_mask_two)
				mask_two_q <= reg_wdata;
			if (hit_config_three)
				config_three_q <= reg_wdata;
			if (hit_limit)
				limit_q <= reg_wdata;
			if (hit_config_four)
				config_four_q <= reg_wdata;
		end
	end

	// sticky status and read data
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			status_two_q <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			status_two_q <= status_two_d;
			if (reg_rd)
				rdata_q <= rdata_d;
		end
	end

	// registered pin and fan outputs
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			alert_n_q <= 1'b1;
			pin5_oe_n_q <= 1'b1;
			shared_oe_n_q <= 1'b1;
			full_speed_q <= 3'b000;
			timer_active_q <= 1'b0;
		end else begin
			alert_n_q <= ~alert_any;
			pin5_oe_n_q <= ~pin5_drive;
			shared_oe_n_q <= ~shared_drive;
			full_speed_q <= full_speed_d;
			timer_active_q <= tif.active;
		end
	end

	// open-drain pins only ever pull low
	assign reg_rdata = rdata_q;
	assign smbalert_n = alert_n_q;
	assign alert_pin5_out = 1'b0;
	assign alert_pin5_oe_n = pin5_oe_n_q;
	assign shared_pin_out = 1'b0;
	assign shared_pin_oe_n = shared_oe_n_q;
	assign fan_full_speed = full_speed_q;
	assign timer_active = timer_active_q;
endmodule : tta_alert_top

// ==== hw/tta_pkg.sv ====
// constants for the overheat assertion timer and alert block
// assumes a 25 MHz core clock and a byte-wide register port
package tta_pkg;
	// register offsets
	localparam logic [7:0] TTA_OFF_STATUS_ONE = 8'h41;
	localparam logic [7:0] TTA_OFF_STATUS_TWO = 8'h42;
	localparam logic [7:0] TTA_OFF_MASK_TWO = 8'h75;
	localparam logic [7:0] TTA_OFF_CONFIG_THREE = 8'h78;
	localparam logic [7:0] TTA_OFF_TIMER = 8'h79;
	localparam logic [7:0] TTA_OFF_LIMIT = 8'h7a;
	localparam logic [7:0] TTA_OFF_CONFIG_FOUR = 8'h7d;

	// reset values
	localparam logic [7:0] TTA_RST_MASK_TWO = 8'h00;
	localparam logic [7:0] TTA_RST_CONFIG_THREE = 8'h00;
	localparam logic [7:0] TTA_RST_LIMIT = 8'h00;
	localparam logic [7:0] TTA_RST_CONFIG_FOUR = 8'h00;

	// config three fields
	localparam int TTA_C3_ALERT_EN = 0;
	localparam int TTA_C3_TIMER_EN = 1;
	localparam int TTA_C3_FULL_SPEED = 2;

	// status two / mask two fields
	localparam int TTA_ST_DIODE_TWO = 7;
	localparam int TTA_ST_DIODE_ONE = 6;
	localparam int TTA_ST_SPEED_FOUR = 5;
	localparam int TTA_ST_SPEED_THREE = 4;
	localparam int TTA_ST_SPEED_TWO = 3;
	localparam int TTA_ST_SPEED_ONE = 2;
	localparam int TTA_ST_OVERTEMP = 1;
	localparam int TTA_ST1_OUT_OF_LIMIT = 7;

	// shared pin roles, config four bits 1:0
	typedef enum logic [1:0] {
		TTA_ROLE_SPEED_IN = 2'b00,
		TTA_ROLE_OVERHEAT = 2'b01,
		TTA_ROLE_ALERT = 2'b10,
		TTA_ROLE_GPIO = 2'b11
	} tta_role_e;

	// timing
	localparam int TTA_CLK_PERIOD_NS = 40;
	localparam int TTA_TICK_US = 22760;
	localparam int TTA_TICK_CYCLES = TTA_TICK_US * 1000 / TTA_CLK_PERIOD_NS;
	localparam int TTA_SUB_W = 20;
	localparam int TTA_FILT_LEN = 3;
	localparam logic [7:0] TTA_TIMER_FULL = 8'hff;
endpackage : tta_pkg

// ==== hw/tta_tmr_if.sv ====
// signals between the alert logic and the assertion accumulator
// assumes both ends on the same core clock
`timescale 1ns/1ps
interface tta_tmr_if;
	logic active;
	logic rd_clr;
	logic [7:0] value;
	modport ctrl (output active, output rd_clr, input value);
	modport tmr (input active, input rd_clr, output value);
endinterface : tta_tmr_if

// ==== hw/tta_sync_filt.sv ====
// two-stage synchroniser and agreement filter for the overheat pin
// assumes an asynchronous active-low pin; output high means asserted
`timescale 1ns/1ps
module tta_sync_filt (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pin_n,
	output logic asserted
);
	import tta_pkg::*;

	logic meta_q;
	logic sync_q;
	logic [TTA_FILT_LEN-1:0] hist_q;
	logic asserted_q;
	wire all_low = (hist_q == '0);
	wire all_high = (hist_q == '1);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			hist_q <= '1;
			asserted_q <= 1'b0;
		end else begin
			meta_q <= pin_n;
			sync_q <= meta_q;
			hist_q <= {hist_q[TTA_FILT_LEN-2:0], sync_q};
			if (all_low)
				asserted_q <= 1'b1;
			else if (all_high)
				asserted_q <= 1'b0;
		end
	end

	assign asserted = asserted_q;
endmodule : tta_sync_filt

// ==== hw/tta_timer.sv ====
// saturating accumulator of overheat assertion time
// assumes active is a clean level on the core clock
`timescale 1ns/1ps
module tta_timer #(
	parameter int TICK_CYCLES = tta_pkg::TTA_TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	tta_tmr_if.tmr tif
);
	import tta_pkg::*;

	localparam logic [TTA_SUB_W-1:0] SUB_LAST = TTA_SUB_W'(TICK_CYCLES - 1);

	logic [TTA_SUB_W-1:0] sub_q;
	logic [7:0] ticks_q;
	logic seen_q;
	wire tick_end = (sub_q == SUB_LAST);
	wire at_full = (ticks_q == TTA_TIMER_FULL);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sub_q <= '0;
			ticks_q <= 8'h00;
			seen_q <= 1'b0;
		end else if (tif.rd_clr) begin
			sub_q <= '0;
			ticks_q <= 8'h00;
			seen_q <= tif.active;
		end else if (tif.active) begin
			seen_q <= 1'b1;
			sub_q <= tick_end ? '0 : sub_q + 1'b1;
			if (tick_end && !at_full)
				ticks_q <= ticks_q + 8'h01;
		end
	end

	assign tif.value = (ticks_q == 8'h00 && seen_q) ? 8'h01 : ticks_q;
endmodule : tta_timer

// ==== testbench/tta_hot_src.sv ====
// stand-in for the processor hot output on the overheat pin
// assumes an open-drain line with a pull-up, so released reads high
`timescale 1ns/1ps
module tta_hot_src (
	input wire logic mclk,
	input wire logic fire,
	input wire logic [15:0] hold,
	output logic pin_n
);
	logic [15:0] cnt_q = 16'h0000;
	// low for hold cycles, then back to the pull-up level
	always_ff @(posedge mclk) begin
		if (fire) begin
			cnt_q <= hold;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	assign pin_n = (cnt_q == 16'h0000);
endmodule : tta_hot_src

// ==== testbench/tta_alert_properties.sv ====
// port assertions for the overheat alert block
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module tta_alert_properties #(
	parameter int TICK_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic overheat_pin_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic overtemp_event,
	input wire logic [2:0] fan_full_speed,
	input wire logic smbalert_n,
	input wire logic alert_pin5_out,
	input wire logic shared_pin_out,
	input wire logic timer_active
);
	logic [7:1] m2_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// shadow of mask two; lands on the same edge as the design's copy
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			m2_q <= 7'h00;
		end else if (reg_wr && reg_addr == 8'h75) begin
			m2_q <= reg_wdata[7:1];
		end
	end
	sequence s_tmr_rd;
		reg_rd && reg_addr == 8'h79;
	endsequence
	chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_pins_drive_low: assert property (!alert_pin5_out && !shared_pin_out)
		else $error("open-drain pin driven high");
	chk_ovt_alerts: assert property (overtemp_event && !m2_q[1] ##1 !m2_q[1]
		|-> ##[0:1] !smbalert_n)
		else $error("overtemperature did not alert");
	chk_mask_quiet: assert property (m2_q == 7'h7f && $past(m2_q) == 7'h7f
		|-> smbalert_n)
		else $error("alert while every source masked");
	chk_full_speed_override_drops: assert property (overheat_pin_n [*8] |=> fan_full_speed == 3'h0)
		else $error("full speed without overheat");
	chk_timer_stops: assert property (overheat_pin_n [*8] |=> !timer_active)
		else $error("timer counting while idle");
	chk_timer_clear: assert property (overheat_pin_n [*8] ##0 s_tmr_rd ##1 s_tmr_rd
		|=> reg_rdata == 8'h00)
		else $error("timer not cleared by read");
	cover property (!smbalert_n);
	cover property (timer_active && fan_full_speed != 3'h0);
	cover property (s_tmr_rd ##1 s_tmr_rd);
endmodule : tta_alert_properties
bind tta_alert_top tta_alert_properties #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk, .rstn,
	.overheat_pin_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .overtemp_event,
	.fan_full_speed, .smbalert_n, .alert_pin5_out, .shared_pin_out, .timer_active);

// ==== testbench/tb.sv ====
// register-level bench for the overheat alert block
// assumes the hot-signal model drives the pin; tick shortened to 8 cycles
`timescale 1ns/1ps
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	import tta_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:1] src = 7'h00;
	logic fire = 1'b0;
	logic [15:0] hold = 16'h0000;
	logic pin_n, smb_n, p5_n, sh_n;
	logic [7:0] reg_rdata, d, b;
	logic [2:0] full;
	int n_fail = 0;
	int total_checks = 0;
	initial forever #20 mclk = ~mclk;
	tta_hot_src hot (.mclk(mclk), .fire(fire), .hold(hold), .pin_n(pin_n));
	tta_alert_top #(.TICK_CYCLES(8)) DUT (.mclk(mclk), .rstn(rstn), .overheat_pin_n(pin_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .diode_two_fault(src[7]), .diode_one_fault(src[6]),
		.speed_fault(src[5:2]), .overtemp_event(src[1]), .fan_manual_mode(3'h3),
		.fan_duty(24'h00_0080), .fan_above_tmin(3'h4), .fan_full_speed(full),
		.smbalert_n(smb_n), .alert_pin5_out(), .alert_pin5_oe_n(p5_n), .shared_pin_out(),
		.shared_pin_oe_n(sh_n), .timer_active());
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask : wt
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// n back-to-back reads; v is what the last one returned
	task automatic rd(input logic [7:0] a, input int n, output logic [7:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		repeat (n) @(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask : rd
	task automatic spike(input logic [7:0] v);
		@(posedge mclk);
		src <= v[7:1];
		@(posedge mclk);
		src <= 7'h00;
		wt(4);
	endtask : spike
	task automatic pulse(input logic [15:0] h);
		@(posedge mclk);
		fire <= 1'b1;
		hold <= h;
		@(posedge mclk);
		fire <= 1'b0;
		@(negedge mclk);
	endtask : pulse
	task automatic idle();
		int k;
		for (k = 0; k < 5000 && pin_n !== 1'b1; k++) @(negedge mclk);
		if (k == 5000) begin
			n_fail++;
			conclude();
		end
		wt(12);
	endtask : idle
	initial begin
		logic [7:0] offs [6] = '{8'h75, 8'h78, 8'h79, 8'h7a, 8'h7d, 8'h00};
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(offs[i], 1, d);
			`CK("reset value", 8'h00, d)
		end
		$display("test resets done");
		for (int i = 1; i < 8; i++) begin
			b = 8'h01 << i;
			wr(TTA_OFF_MASK_TWO, b);
			spike(b);
			`CK("masked alert", 1'b1, smb_n)
			rd(TTA_OFF_STATUS_TWO, 1, d);
			`CK("status", b, d)
			rd(TTA_OFF_STATUS_TWO, 1, d);
			`CK("status clear", 8'h00, d)
			wr(TTA_OFF_MASK_TWO, 8'h00);
			spike(b);
			`CK("alert", 1'b0, smb_n)
			rd(TTA_OFF_STATUS_TWO, 1, d);
			wt(2);
			`CK("alert off", 1'b1, smb_n)
		end
		$display("test masks done");
		wr(TTA_OFF_CONFIG_THREE, 8'h02);
		pulse(16'h00c8);
		idle();
		rd(TTA_OFF_TIMER, 1, d);
		`CK("wrong role", 8'h00, d)
		wr(TTA_OFF_CONFIG_FOUR, 8'h01);
		wr(TTA_OFF_CONFIG_THREE, 8'h04);
		pulse(16'h00c8);
		wt(100);
		`CK("full speed", 3'h5, full)
		idle();
		rd(TTA_OFF_TIMER, 1, d);
		`CK("no enable", 8'h00, d)
		$display("test roles done");
		wr(TTA_OFF_CONFIG_THREE, 8'h06);
		wr(TTA_OFF_MASK_TWO, 8'h20);
		wr(TTA_OFF_LIMIT, 8'h01);
		pulse(16'h0002);
		idle();
		rd(TTA_OFF_TIMER, 1, d);
		`CK("glitch", 8'h00, d)
		pulse(16'h03ee);
		idle();
		pulse(16'h03ee);
		idle();
		`CK("masked timer", 1'b1, smb_n)
		rd(TTA_OFF_STATUS_TWO, 1, d);
		`CK("limit flag", 8'h20, d)
		rd(TTA_OFF_TIMER, 1, d);
		`CK("accumulated", 1'b1, d >= 8'hf9 && d <= 8'hfd)
		rd(TTA_OFF_STATUS_TWO, 1, d);
		`CK("flag cleared", 8'h00, d)
		$display("test accumulate done");
		wr(TTA_OFF_MASK_TWO, 8'h00);
		wr(TTA_OFF_LIMIT, 8'h00);
		pulse(16'h0898);
		idle();
		`CK("limit alert", 1'b0, smb_n)
		wr(TTA_OFF_MASK_TWO, 8'hfe);
		wt(3);
		`CK("all masked", 1'b1, smb_n)
		wr(TTA_OFF_MASK_TWO, 8'h00);
		wr(TTA_OFF_CONFIG_THREE, 8'h07);
		wt(3);
		`CK("pin5 drive", 1'b0, p5_n)
		rd(TTA_OFF_TIMER, 1, d);
		`CK("saturated", TTA_TIMER_FULL, d)
		rd(TTA_OFF_TIMER, 2, d);
		`CK("read clear", 8'h00, d)
		wt(2);
		`CK("alert released", 1'b1, smb_n)
		`CK("pin5 release", 1'b1, p5_n)
		$display("test saturate done");
		pulse(16'h012c);
		wt(150);
		rd(TTA_OFF_TIMER, 2, d);
		`CK("restart", 8'h01, d)
		wt(2);
		rd(TTA_OFF_STATUS_TWO, 1, d);
		`CK("flag again", 8'h20, d)
		idle();
		wr(TTA_OFF_CONFIG_FOUR, 8'h02);
		wt(3);
		`CK("shared alert", 1'b0, sh_n)
		$display("test restart done");
		conclude();
	end
endmodule : tb
